// ==== logic/tpwm_pkg.sv ====
package tpwm_pkg;
    // ****************************************************************
    // register map (byte addresses on apb)
    // ****************************************************************
    localparam logic [7:0]  ADDR_CONTROL  = 8'h00;
    localparam logic [7:0]  ADDR_COUNT    = 8'h04;
    localparam logic [7:0]  ADDR_COMPARE  = 8'h08;
    localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
    localparam logic [7:0]  ADDR_PIN      = 8'h10;

    // ****************************************************************
    // control register fields
    // ****************************************************************
    localparam int          CTL_FORCE_BIT = 7;
    localparam int          CTL_WGM0_BIT  = 6;
    localparam int          CTL_COM_HI    = 5;
    localparam int          CTL_COM_LO    = 4;
    localparam int          CTL_WGM1_BIT  = 3;
    localparam int          CTL_CS_HI     = 2;
    localparam logic [7:0]  CTL_RESET     = 8'h00;

    // status register fields, write one to clear
    localparam int          ST_OVF_BIT    = 0;
    localparam int          ST_CMP_BIT    = 1;

    // ****************************************************************
    // mode and action encodings
    // ****************************************************************
    localparam logic [1:0]  MODE_NORMAL   = 2'h0;
    localparam logic [1:0]  MODE_PHASE    = 2'h1;
    localparam logic [1:0]  MODE_CTC      = 2'h2;
    localparam logic [1:0]  MODE_FAST     = 2'h3;

    localparam logic [1:0]  ACT_NONE      = 2'h0;
    localparam logic [1:0]  ACT_TOGGLE    = 2'h1;
    localparam logic [1:0]  ACT_CLEAR     = 2'h2;
    localparam logic [1:0]  ACT_SET       = 2'h3;

    localparam logic [7:0]  CNT_MAX       = 8'hFF;
    localparam logic [7:0]  CNT_BOTTOM    = 8'h00;

    // ****************************************************************
    // prescaler
    // ****************************************************************
    localparam logic [9:0]  DIV8_MASK     = 10'h007;
    localparam logic [9:0]  DIV64_MASK    = 10'h03F;
    localparam logic [9:0]  DIV256_MASK   = 10'h0FF;
    localparam logic [9:0]  DIV1024_MASK  = 10'h3FF;

    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] cnt;
        logic [7:0] ocr_buf;
        logic [7:0] ocr;
        logic       down;
        logic       oc;
        logic       ovf;
        logic       cmp;
        logic       blk;
        logic [9:0] pre;
        logic [31:0] rdata;
    } tpwm_state_s;
endpackage : tpwm_pkg

// ==== logic/tpwm_top.sv ====
// Function
// - mode 3 counts zero up to max then restarts at zero
// - fast pwm: action 2 clears on match sets at bottom, 3 inverse
// - fast pwm: max to zero wrap and bottom output update in one tick
// - fast pwm: overflow flag set when counter reaches max
// - fast pwm period is 256 ticks
// - fast pwm: compare zero gives spike, compare max gives constant level
// - fast pwm action 1 toggles output on every match
// - fast pwm compare value is double buffered
// - mode 1 counts up to max then down to zero
// - phase pwm: action 2 clears on up match, sets on down match; 3 inverse
// - phase pwm resolution fixed at 8 bits
// - phase pwm reverses at max and holds max exactly one tick
// - phase pwm period is 510 ticks
// - phase pwm: overflow flag set when counter reaches zero
// - phase pwm: compare zero constant low, max constant high, inverted opposite
// - phase pwm forces up-count result at max, or the down-count result when the buffered compare value is max
// - tick is io clock divided by 1, 8, 64, 256 or 1024
// - fully synchronous; tick is only a clock enable
// - force strobe in non-pwm mode applies immediate compare action
// - force sets no flag, clears no counter, reads back zero
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module tpwm_top (
    input  wire logic        SYS_CLK_I,   // io clock 25 mhz
    input  wire logic        ARST_N_I,    // async reset, active low
    input  wire logic        PSEL_I,      // apb select
    input  wire logic        PENABLE_I,   // apb enable
    input  wire logic        PWRITE_I,    // apb direction
    input  wire logic [7:0]  PADDR_I,     // apb byte address
    input  wire logic [31:0] PWDATA_I,    // apb write data
    output logic      [31:0] PRDATA_O,    // apb read data
    output logic             PREADY_O,    // apb ready
    output logic             PSLVERR_O,   // apb error on unmapped address
    output logic             OC_PIN_O,    // compare output pin level
    output logic             OC_PIN_OE_N_O, // pin enable, low drives
    output logic             OVF_FLAG_O,  // overflow flag
    output logic             CMP_FLAG_O   // compare match flag
);

    // ****************************************************************
    // state
    // ****************************************************************
    tpwm_pkg::tpwm_state_s s_q;
    tpwm_pkg::tpwm_state_s s_d;
    logic                  dir_q;
    logic                  dir_d;

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == tpwm_pkg::ADDR_CONTROL) || (a == tpwm_pkg::ADDR_COUNT) ||
                     (a == tpwm_pkg::ADDR_COMPARE) || (a == tpwm_pkg::ADDR_STATUS) ||
                     (a == tpwm_pkg::ADDR_PIN);
    endfunction

    function automatic logic apply_act(input logic [1:0] act, input logic cur);
        case (act)
            tpwm_pkg::ACT_TOGGLE: apply_act = ~cur;
            tpwm_pkg::ACT_CLEAR:  apply_act = 1'b0;
            tpwm_pkg::ACT_SET:    apply_act = 1'b1;
            default:              apply_act = cur;
        endcase
    endfunction

    logic [1:0] mode;
    logic [1:0] act;
    logic [2:0] cs;
    logic       tick;
    logic       pwm;
    logic       wr;
    logic       rd;
    logic       match;

    always_comb begin
        mode  = {s_q.ctl[tpwm_pkg::CTL_WGM1_BIT], s_q.ctl[tpwm_pkg::CTL_WGM0_BIT]};
        act   = s_q.ctl[tpwm_pkg::CTL_COM_HI:tpwm_pkg::CTL_COM_LO];
        cs    = s_q.ctl[tpwm_pkg::CTL_CS_HI:0];
        pwm   = (mode == tpwm_pkg::MODE_FAST) || (mode == tpwm_pkg::MODE_PHASE);
        wr    = PSEL_I && PENABLE_I && PWRITE_I && addr_known(PADDR_I);
        rd    = PSEL_I && !PENABLE_I && !PWRITE_I;
        match = (s_q.cnt == s_q.ocr) && !s_q.blk;
        // ************************************************************
        // prescaler tick
        // ************************************************************
        case (cs)
            3'h1:    tick = 1'b1;
            3'h2:    tick = (s_q.pre & tpwm_pkg::DIV8_MASK) == tpwm_pkg::DIV8_MASK;
            3'h3:    tick = (s_q.pre & tpwm_pkg::DIV64_MASK) == tpwm_pkg::DIV64_MASK;
            3'h4:    tick = (s_q.pre & tpwm_pkg::DIV256_MASK) == tpwm_pkg::DIV256_MASK;
            3'h5:    tick = s_q.pre == tpwm_pkg::DIV1024_MASK;
            default: tick = 1'b0;
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_d   = s_q;
        dir_d = dir_q;
        s_d.pre = (cs == 3'h0) ? 10'h000 : s_q.pre + 10'h001;
        if (tick) begin
            s_d.blk = 1'b0;
            case (mode)
                tpwm_pkg::MODE_FAST: begin
                    if (s_q.cnt == tpwm_pkg::CNT_MAX) begin
                        s_d.cnt = tpwm_pkg::CNT_BOTTOM;
                        s_d.ocr = s_q.ocr_buf;
                        if (act[1])
                            s_d.oc = ~act[0];
                        else if (match)
                            s_d.oc = apply_act(act, s_q.oc);
                    end else begin
                        s_d.cnt = s_q.cnt + 8'h01;
                        if (match)
                            s_d.oc = apply_act(act, s_q.oc);
                    end
                    if (s_q.cnt == tpwm_pkg::CNT_MAX - 8'h01)
                        s_d.ovf = 1'b1;
                end
                tpwm_pkg::MODE_PHASE: begin
                    if (!s_q.down) begin
                        if (s_q.cnt == tpwm_pkg::CNT_MAX - 8'h01)
                            s_d.down = 1'b1;
                        s_d.cnt = s_q.cnt + 8'h01;
                        if (s_q.cnt == tpwm_pkg::CNT_MAX) begin
                            s_d.down = 1'b1;
                            s_d.cnt  = s_q.cnt - 8'h01;
                        end
                        if (match && act[1])
                            s_d.oc = act[0];
                    end else begin
                        if (s_q.cnt == tpwm_pkg::CNT_MAX) begin
                            s_d.ocr = s_q.ocr_buf;
                            // at max the output takes the up-count result, or stays at the max level
                            if (act[1])
                                s_d.oc = (s_q.ocr_buf == tpwm_pkg::CNT_MAX) ? ~act[0] : act[0];
                        end else if (match && act[1]) begin
                            s_d.oc = ~act[0];
                        end
                        if (s_q.cnt == tpwm_pkg::CNT_BOTTOM + 8'h01) begin
                            s_d.down = 1'b0;
                            s_d.ovf  = 1'b1;
                        end
                        s_d.cnt = s_q.cnt - 8'h01;
                        if (s_q.cnt == tpwm_pkg::CNT_BOTTOM) begin
                            s_d.down = 1'b0;
                            s_d.cnt  = s_q.cnt + 8'h01;
                        end
                    end
                    if (s_q.ocr == tpwm_pkg::CNT_BOTTOM && act[1])
                        s_d.oc = act[0];
                end
                default: begin
                    s_d.down = 1'b0;
                    s_d.ocr  = s_q.ocr_buf;
                    if (mode == tpwm_pkg::MODE_CTC && match)
                        s_d.cnt = tpwm_pkg::CNT_BOTTOM;
                    else
                        s_d.cnt = s_q.cnt + 8'h01;
                    if (s_q.cnt == tpwm_pkg::CNT_MAX)
                        s_d.ovf = 1'b1;
                    if (match)
                        s_d.oc = apply_act(act, s_q.oc);
                end
            endcase
            if (match)
                s_d.cmp = 1'b1;
        end
        if (!pwm)
            s_d.ocr = s_q.ocr_buf;
        // ************************************************************
        // register writes
        // ************************************************************
        if (wr) begin
            case (PADDR_I)
                tpwm_pkg::ADDR_CONTROL: begin
                    s_d.ctl = PWDATA_I[7:0];
                    s_d.ctl[tpwm_pkg::CTL_FORCE_BIT] = 1'b0;
                    if (PWDATA_I[tpwm_pkg::CTL_FORCE_BIT] &&
                        PWDATA_I[tpwm_pkg::CTL_WGM0_BIT] == 1'b0)
                        s_d.oc = apply_act(PWDATA_I[tpwm_pkg::CTL_COM_HI:tpwm_pkg::CTL_COM_LO], s_q.oc);
                end
                tpwm_pkg::ADDR_COUNT: begin
                    s_d.cnt = PWDATA_I[7:0];
                    s_d.blk = 1'b1;
                end
                tpwm_pkg::ADDR_COMPARE: s_d.ocr_buf = PWDATA_I[7:0];
                tpwm_pkg::ADDR_STATUS: begin
                    if (PWDATA_I[tpwm_pkg::ST_OVF_BIT] && !(s_d.ovf && !s_q.ovf))
                        s_d.ovf = 1'b0;
                    if (PWDATA_I[tpwm_pkg::ST_CMP_BIT] && !(s_d.cmp && !s_q.cmp))
                        s_d.cmp = 1'b0;
                end
                tpwm_pkg::ADDR_PIN: dir_d = PWDATA_I[0];
                default: ;
            endcase
        end
        // ************************************************************
        // read data
        // ************************************************************
        if (rd) begin
            case (PADDR_I)
                tpwm_pkg::ADDR_CONTROL: s_d.rdata = {24'h000000, 1'b0, s_q.ctl[6:0]};
                tpwm_pkg::ADDR_COUNT:   s_d.rdata = {24'h000000, s_q.cnt};
                tpwm_pkg::ADDR_COMPARE: s_d.rdata = {24'h000000, s_q.ocr_buf};
                tpwm_pkg::ADDR_STATUS:  s_d.rdata = {30'h00000000, s_q.cmp, s_q.ovf};
                tpwm_pkg::ADDR_PIN:     s_d.rdata = {30'h00000000, s_q.oc, dir_q};
                default:                s_d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            s_q     <= '0;
            s_q.ctl <= tpwm_pkg::CTL_RESET;
            dir_q   <= 1'b0;
        end else begin
            s_q   <= s_d;
            dir_q <= dir_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign PRDATA_O      = s_q.rdata;
    assign PREADY_O      = 1'b1;
    assign PSLVERR_O     = PSEL_I && PENABLE_I && !addr_known(PADDR_I);
    // pin shows oc only when an action is selected, else drives low
    assign OC_PIN_O      = (act != tpwm_pkg::ACT_NONE) ? s_q.oc : 1'b0;
    assign OC_PIN_OE_N_O = !dir_q;
    assign OVF_FLAG_O    = s_q.ovf;
    assign CMP_FLAG_O    = s_q.cmp;

endmodule // tpwm_top

// ==== dv/tpwm_checker.sv ====
`timescale 1ns/1ps
module tpwm_checker (
    input wire logic        SYS_CLK_I,     // io clock
    input wire logic        ARST_N_I,      // reset, active low
    input wire logic        PSEL_I,        // apb select
    input wire logic        PENABLE_I,     // apb enable
    input wire logic        PWRITE_I,      // apb direction
    input wire logic [7:0]  PADDR_I,       // apb address
    input wire logic [31:0] PWDATA_I,      // apb write data
    input wire logic [31:0] PRDATA_O,      // apb read data
    input wire logic        PREADY_O,      // apb ready
    input wire logic        PSLVERR_O,     // apb error
    input wire logic        OC_PIN_O,      // compare output
    input wire logic        OC_PIN_OE_N_O, // pin enable, low drives
    input wire logic        OVF_FLAG_O,    // overflow flag
    input wire logic        CMP_FLAG_O     // compare flag
);
    // ****
    // shadow of the control register
    // ****
    logic       wr;
    logic       mapped;
    logic [7:0] ctl_q;
    assign wr = PSEL_I && PENABLE_I && PWRITE_I;
    assign mapped = PADDR_I inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ctl_q <= 8'h00;
        end else if (wr && PADDR_I == tpwm_pkg::ADDR_CONTROL) begin
            ctl_q <= PWDATA_I[7:0];
        end
    end
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!ARST_N_I);
    sequence s_pin_on;
        wr && PADDR_I == tpwm_pkg::ADDR_PIN && PWDATA_I[0];
    endsequence
    sequence s_ctl_read;
        PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == tpwm_pkg::ADDR_CONTROL ##1 PENABLE_I;
    endsequence
    logic ovf_clr;
    logic cmp_clr;
    assign ovf_clr = wr && PADDR_I == tpwm_pkg::ADDR_STATUS && PWDATA_I[0];
    assign cmp_clr = wr && PADDR_I == tpwm_pkg::ADDR_STATUS && PWDATA_I[1];
    a_ready_high: assert property (PREADY_O) else $error("ready low");
    a_unmapped_err: assert property (PSEL_I && PENABLE_I && !mapped |-> PSLVERR_O) else $error("no error");
    a_mapped_ok: assert property (PSEL_I && PENABLE_I && mapped |-> !PSLVERR_O) else $error("false error");
    a_dir_drives:
        assert property (s_pin_on |=> !OC_PIN_OE_N_O) else $error("pin not driven");
    a_force_reads0:
        assert property (s_ctl_read |-> !PRDATA_O[7]) else $error("force bit read as one");
    a_upper_zero: assert property (PRDATA_O[31:8] == 24'h0) else $error("upper read bits set");
    a_pin_gated:
        assert property (ctl_q[5:4] == 2'h0 |-> !OC_PIN_O) else $error("pin active without action");
    a_ovf_sticky:
        assert property (OVF_FLAG_O && !ovf_clr |=> OVF_FLAG_O) else $error("overflow flag lost");
    a_cmp_sticky: assert property (CMP_FLAG_O && !cmp_clr |=> CMP_FLAG_O) else $error("compare flag lost");
endmodule // tpwm_checker
bind tpwm_top tpwm_checker u_tpwm_checker (.SYS_CLK_I(SYS_CLK_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .OC_PIN_O(OC_PIN_O), .OC_PIN_OE_N_O(OC_PIN_OE_N_O),
    .OVF_FLAG_O(OVF_FLAG_O), .CMP_FLAG_O(CMP_FLAG_O));

// ==== dv/tpwm_load.sv ====
`timescale 1ns/1ps
module tpwm_load (
    input  wire logic clk_i,    // io clock
    input  wire logic rst_n_i,  // reset, active low
    input  wire logic pin_i,    // pin level from block
    input  wire logic oe_n_i,   // pin enable, low drives
    output int        rises_o,  // rising edges seen
    output int        period_o  // cycles between last two rises
);
    logic lvl;
    logic lvl_q;
    int   since;
    assign lvl = oe_n_i ? 1'b0 : pin_i;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lvl_q <= 1'b0;
            since <= 0;
            rises_o <= 0;
            period_o <= 0;
        end else begin
            lvl_q <= lvl;
            since <= (lvl && !lvl_q) ? 1 : since + 1;
            if (lvl && !lvl_q) begin
                rises_o <= rises_o + 1;
                period_o <= since;
            end
        end
    end
endmodule // tpwm_load

// ==== dv/tpwm_top_test.sv ====
`timescale 1ns/1ps
module tpwm_top_test;
    logic        clk;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, perr, err, pin, oe_n, ovf, cmp;
    int          n_mismatch = 0, comparisons = 0, cyc = 0, rises, period, r0;
    // ctl, compare, period (0 = constant level)
    int tbl[7][4] = '{'{8'h69, 8'h80, 256, 0}, '{8'h79, 8'h80, 256, 0}, '{8'h59, 8'h00, 512, 0},
                      '{8'h61, 8'h80, 510, 0}, '{8'h71, 8'h80, 510, 0}, '{8'h69, 8'hFF, 0, 1}, '{8'h61, 8'h00, 0, 0}};
    tpwm_top u_tpwm_top (.SYS_CLK_I(clk), .ARST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(perr),
        .OC_PIN_O(pin), .OC_PIN_OE_N_O(oe_n), .OVF_FLAG_O(ovf), .CMP_FLAG_O(cmp));
    tpwm_load u_tpwm_load (.clk_i(clk), .rst_n_i(rst_n), .pin_i(pin), .oe_n_i(oe_n), .rises_o(rises),
        .period_o(period));
    // ****
    // bus and compare tasks
    // ****
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ****
    // clock, timeout, tests
    // ****
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        xfer(1'b0, tpwm_pkg::ADDR_CONTROL, 32'h0);
        chk("control", rd, 32'h0);
        xfer(1'b0, 8'h14, 32'h0);
        chk("slverr", 32'(err), 32'h1);
        chk("unmapped", rd, 32'h0);
        $display("test reset done");
        xfer(1'b1, tpwm_pkg::ADDR_PIN, 32'h1);
        chk("oe_n", 32'(oe_n), 32'h0);
        xfer(1'b1, tpwm_pkg::ADDR_CONTROL, 32'hB0);
        chk("pin", 32'(pin), 32'h1);
        xfer(1'b0, tpwm_pkg::ADDR_CONTROL, 32'h0);
        chk("control", rd, 32'h30);
        chk("cmp flag", 32'(cmp), 32'h0);
        xfer(1'b1, tpwm_pkg::ADDR_CONTROL, 32'hA0);
        chk("pin", 32'(pin), 32'h0);
        $display("test force done");
        for (int i = 0; i < 7; i++) begin
            xfer(1'b1, tpwm_pkg::ADDR_COMPARE, 32'(tbl[i][1]));
            xfer(1'b1, tpwm_pkg::ADDR_CONTROL, 32'(tbl[i][0]));
            xfer(1'b1, tpwm_pkg::ADDR_STATUS, 32'h1);
            repeat (1600) @(posedge clk);
            r0 = rises;
            if (tbl[i][2] != 0) begin
                chk("period", 32'(period), 32'(tbl[i][2]));
            end else begin
                repeat (600) @(posedge clk);
                chk("edges", 32'(rises - r0), 32'h0);
                chk("level", 32'(pin), 32'(tbl[i][3]));
            end
            chk("ovf flag", 32'(ovf), 32'h1);
        end
        $display("test pwm done");
        xfer(1'b1, tpwm_pkg::ADDR_CONTROL, 32'h0);
        xfer(1'b1, tpwm_pkg::ADDR_STATUS, 32'h3);
        xfer(1'b0, tpwm_pkg::ADDR_STATUS, 32'h0);
        chk("status", rd, 32'h0);
        $display("test status done");
        wrap_up();
    end
endmodule // tpwm_top_test
